// ==== design/ldw_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldw_top
   import ldw_pkg::*;
#(
   parameter logic [15:0] SLOT_CYCLES = 16'(LDW_SLOT_CYC)
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic write_strobe,
   input wire logic register_select,
   input wire logic input_line_0,
   input wire logic input_line_1,
   input wire logic input_line_2,
   input wire logic input_line_3_bank_sel,
   input wire logic input_line_4_power,
   input wire logic input_line_5_raw_sel,
   input wire logic input_line_6_charset,
   input wire logic input_line_7_seq_flag,
   output logic [6:0] segment_out,
   output logic decimal_point_output,
   output logic [7:0] digit_out
);
   localparam logic [15:0] BLANK_CYCLES = 16'(LDW_BLANK_CYC);

   ldw_host_bus_type pin_bus;
   ldw_host_bus_type sync1_reg, sync2_reg;
   logic strobe1_reg, strobe2_reg, strobe3_reg;
   logic wr_pulse;

   assign pin_bus = {register_select, input_line_7_seq_flag, input_line_6_charset, input_line_5_raw_sel,
                     input_line_4_power, input_line_3_bank_sel, input_line_2, input_line_1, input_line_0};

   // Pins cross two flip-flops before use.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         strobe1_reg <= 1'b1;
         strobe2_reg <= 1'b1;
         strobe3_reg <= 1'b1;
      end else begin
         sync1_reg <= pin_bus;
         sync2_reg <= sync1_reg;
         strobe1_reg <= write_strobe;
         strobe2_reg <= strobe1_reg;
         strobe3_reg <= strobe2_reg;
      end
   end

   assign wr_pulse = strobe2_reg & ~strobe3_reg;

   // Write side: control word, update mode and RAM write address.
   ldw_ctrl_type ctrl_reg, ctrl_next;
   ldw_wstate_type wstate_reg, wstate_next;
   logic [2:0] seq_cnt_reg, seq_cnt_next;
   logic ram_we;
   logic [2:0] wr_digit;
   logic [3:0] ram_waddr;

   always_comb begin
      ctrl_next = ctrl_reg;
      wstate_next = wstate_reg;
      seq_cnt_next = seq_cnt_reg;
      ram_we = 1'b0;
      wr_digit = ctrl_reg.addr;
      if (wr_pulse && sync2_reg.sel) begin
         ctrl_next = ldw_ctrl_type'(sync2_reg.data);
         seq_cnt_next = 3'h0;
         wstate_next = sync2_reg.data[LDW_SEQ_BIT] ? LDW_SEQ : LDW_SINGLE;
      end else if (wr_pulse) begin
         unique case (wstate_reg)
            LDW_SEQ: begin
               ram_we = 1'b1;
               wr_digit = seq_cnt_reg;
               seq_cnt_next = seq_cnt_reg + 3'h1;
               if (seq_cnt_reg == 3'h7) begin
                  wstate_next = LDW_HOLD;
               end
            end
            LDW_SINGLE: begin
               ram_we = 1'b1;
               wr_digit = ctrl_reg.addr;
            end
            LDW_HOLD: begin
               ram_we = 1'b0;
            end
            default: begin
               wstate_next = LDW_HOLD;
            end
         endcase
      end
   end

   // Raw segment data always lives in bank A; the bank bit steers decode modes only.
   assign ram_waddr = {ctrl_reg.bank_a | ctrl_reg.raw, wr_digit};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= ldw_ctrl_type'(LDW_CTRL_RESET);
         wstate_reg <= LDW_HOLD;
         seq_cnt_reg <= 3'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         wstate_reg <= wstate_next;
         seq_cnt_reg <= seq_cnt_next;
      end
   end

   // Scan side: digit slot counter, blanking and segment decode.
   logic [15:0] slot_cnt_reg, slot_cnt_next;
   logic [2:0] scan_reg, scan_next;
   logic [7:0] ram_rdata;
   logic [6:0] dec_seg;
   logic [6:0] seg_next;
   logic dp_next;
   logic [7:0] digit_next;
   logic [6:0] segment_reg;
   logic dp_reg;
   logic [7:0] digit_reg;

   ldw_ram u_ram (
      .ref_clk(ref_clk),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(sync2_reg.data),
      .raddr({ctrl_reg.bank_a | ctrl_reg.raw, scan_reg}),
      .rdata(ram_rdata)
   );

   // Segment order is {g,f,e,d,c,b,a}.
   always_comb begin
      unique case (ram_rdata[3:0])
         4'h0: dec_seg = 7'h3F;
         4'h1: dec_seg = 7'h06;
         4'h2: dec_seg = 7'h5B;
         4'h3: dec_seg = 7'h4F;
         4'h4: dec_seg = 7'h66;
         4'h5: dec_seg = 7'h6D;
         4'h6: dec_seg = 7'h7D;
         4'h7: dec_seg = 7'h07;
         4'h8: dec_seg = 7'h7F;
         4'h9: dec_seg = 7'h6F;
         4'hA: dec_seg = ctrl_reg.hex ? 7'h77 : 7'h40;
         4'hB: dec_seg = ctrl_reg.hex ? 7'h7C : 7'h79;
         4'hC: dec_seg = ctrl_reg.hex ? 7'h39 : 7'h76;
         4'hD: dec_seg = ctrl_reg.hex ? 7'h5E : 7'h38;
         4'hE: dec_seg = ctrl_reg.hex ? 7'h79 : 7'h73;
         4'hF: dec_seg = ctrl_reg.hex ? 7'h71 : 7'h00;
      endcase
   end

   always_comb begin
      slot_cnt_next = slot_cnt_reg;
      scan_next = scan_reg;
      digit_next = 8'h00;
      seg_next = 7'h00;
      dp_next = 1'b0;
      if (ctrl_reg.power) begin
         if (slot_cnt_reg >= SLOT_CYCLES - 16'h0001) begin
            slot_cnt_next = 16'h0000;
            scan_next = scan_reg + 3'h1;
         end else begin
            slot_cnt_next = slot_cnt_reg + 16'h0001;
         end
         if (slot_cnt_reg >= BLANK_CYCLES) begin
            digit_next = 8'h01 << scan_reg;
            seg_next = ctrl_reg.raw ? ram_rdata[6:0] : dec_seg;
            dp_next = ram_rdata[LDW_DP_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         slot_cnt_reg <= 16'h0000;
         scan_reg <= 3'h0;
         digit_reg <= 8'h00;
         segment_reg <= 7'h00;
         dp_reg <= 1'b0;
      end else begin
         slot_cnt_reg <= slot_cnt_next;
         scan_reg <= scan_next;
         digit_reg <= digit_next;
         segment_reg <= seg_next;
         dp_reg <= dp_next;
      end
   end

   assign digit_out = digit_reg;
   assign segment_out = segment_reg;
   assign decimal_point_output = dp_reg;

   // Counts the cycles for which every digit has been dark, so the blanking check can see the whole gap.
   logic [15:0] dark_cnt_reg, dark_cnt_next;

   always_comb begin
      dark_cnt_next = 16'h0000;
      if (digit_reg == 8'h00) begin
         dark_cnt_next = (dark_cnt_reg == 16'hFFFF) ? dark_cnt_reg : dark_cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dark_cnt_reg <= 16'h0000;
      end else begin
         dark_cnt_reg <= dark_cnt_next;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence data_write_s;
      wr_pulse && !sync2_reg.sel;
   endsequence

   sequence digit_release_s;
      digit_reg != 8'h00 ##1 digit_reg == 8'h00;
   endsequence

   ctrl_load_a: assert property (wr_pulse && sync2_reg.sel |=> ctrl_reg == $past(sync2_reg.data))
      else $error("control word not loaded on write edge");
   ram_load_a: assert property (data_write_s and wstate_reg != LDW_HOLD |-> ram_we && ctrl_next == ctrl_reg)
      else $error("display data write not stored");
   seq_order_a: assert property (data_write_s and wstate_reg == LDW_SEQ |-> ram_waddr[2:0] == seq_cnt_reg)
      else $error("sequential write to wrong digit");
   seq_end_a: assert property (data_write_s and wstate_reg == LDW_SEQ && seq_cnt_reg == 3'h7 |=> wstate_reg == LDW_HOLD)
      else $error("sequential update did not stop after eight writes");
   single_addr_a: assert property (data_write_s and wstate_reg == LDW_SINGLE |-> ram_waddr[2:0] == ctrl_reg.addr)
      else $error("single-digit write to wrong digit");
   hold_ignore_a: assert property (wstate_reg == LDW_HOLD |-> !ram_we)
      else $error("RAM written outside an update");
   shutdown_blank_a: assert property (!ctrl_reg.power |=> digit_reg == 8'h00 && segment_reg == 7'h00)
      else $error("display not blanked in shutdown");
   digit_onehot_a: assert property ($onehot0(digit_reg))
      else $error("digit drives overlap");
   blank_gap_a: assert property (digit_release_s |-> digit_reg == 8'h00 [*8])
      else $error("inter-digit blanking too short");
   blank_len_a: assert property (digit_reg == 8'h00 && digit_next != 8'h00 |->
      dark_cnt_reg >= BLANK_CYCLES - 16'h0001)
      else $error("inter-digit blanking shorter than the minimum");
   slot_bound_a: assert property (slot_cnt_reg < SLOT_CYCLES)
      else $error("scan slot counter overran");
   mode_pick_a: assert property (ctrl_reg.power && !ctrl_reg.raw && slot_cnt_reg >= BLANK_CYCLES |=> segment_reg == $past(dec_seg))
      else $error("decoded segments not shown");
endmodule : ldw_top
`default_nettype wire

// ==== design/ldw_pkg.sv ====
package ldw_pkg;
   localparam int LDW_CLK_HZ = 100_000_000;
   localparam int LDW_CLK_NS = 10;
   localparam int LDW_DIGITS = 8;
   localparam int LDW_SCAN_HZ = 390;
   localparam int LDW_BLANK_NS = 2000;
   localparam int LDW_BLANK_CYC = (LDW_BLANK_NS + LDW_CLK_NS - 1) / LDW_CLK_NS;
   localparam int LDW_SLOT_CYC = LDW_CLK_HZ / (LDW_SCAN_HZ * LDW_DIGITS);

   // Control word field positions, and the decimal-point bit of the display data.
   localparam int LDW_SEQ_BIT = 7;
   localparam int LDW_HEX_BIT = 6;
   localparam int LDW_RAW_BIT = 5;
   localparam int LDW_PWR_BIT = 4;
   localparam int LDW_BANK_BIT = 3;
   localparam int LDW_ADDR_LSB = 0;
   localparam int LDW_DP_BIT = 7;

   // Normal operation, code-B decode, digit 0 in bank A; data writes are held off until a control write, since reset puts the write side in LDW_HOLD.
   localparam logic [7:0] LDW_CTRL_RESET = 8'h18;

   typedef struct packed {
      logic seq;
      logic hex;
      logic raw;
      logic power;
      logic bank_a;
      logic [2:0] addr;
   } ldw_ctrl_type;

   typedef struct packed {
      logic sel;
      logic [7:0] data;
   } ldw_host_bus_type;

   typedef enum logic [2:0] {
      LDW_HOLD = 3'h1,
      LDW_SEQ = 3'h2,
      LDW_SINGLE = 3'h4
   } ldw_wstate_type;
endpackage : ldw_pkg

// ==== design/ldw_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldw_ram (
   input wire logic ref_clk,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [3:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem_reg [16];
   logic [7:0] rdata_reg;

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
      rdata_reg <= mem_reg[raddr];
   end

   assign rdata = rdata_reg;
endmodule : ldw_ram
`default_nettype wire

// ==== sim/ldw_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldw_host_model
   import ldw_pkg::*;
(
   input wire logic ref_clk,
   output logic write_strobe,
   output var ldw_host_bus_type host_bus
);
   initial begin
      write_strobe = 1'b1;
      host_bus = '0;
   end

   // One write: select and data settle well before the strobe rise and are held past it.
   task automatic write(input logic sel, input logic [7:0] data);
      @(posedge ref_clk);
      host_bus <= {sel, data};
      repeat (5) @(posedge ref_clk);
      write_strobe <= 1'b0;
      repeat (4) @(posedge ref_clk);
      write_strobe <= 1'b1;
      repeat (5) @(posedge ref_clk);
      // Once the hold time has passed the bus no longer shows the written value.
      host_bus <= ~host_bus;
   endtask : write
endmodule : ldw_host_model
`default_nettype wire

// ==== sim/ldw_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldw_top_tb
   import ldw_pkg::*;
;
   localparam int SLOT = 300;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic write_strobe;
   ldw_host_bus_type host_bus;
   logic [6:0] segment_out;
   logic decimal_point_output;
   logic [7:0] digit_out;
   int err_count = 0;
   int checked = 0;

   always #5 ref_clk = ~ref_clk;

   ldw_host_model host_u (.ref_clk(ref_clk), .write_strobe(write_strobe), .host_bus(host_bus));

   ldw_top #(.SLOT_CYCLES(16'(SLOT))) dut_u (
      .ref_clk(ref_clk), .rst(rst), .write_strobe(write_strobe), .register_select(host_bus.sel),
      .input_line_0(host_bus.data[0]), .input_line_1(host_bus.data[1]), .input_line_2(host_bus.data[2]),
      .input_line_3_bank_sel(host_bus.data[3]), .input_line_4_power(host_bus.data[4]),
      .input_line_5_raw_sel(host_bus.data[5]), .input_line_6_charset(host_bus.data[6]),
      .input_line_7_seq_flag(host_bus.data[7]), .segment_out(segment_out),
      .decimal_point_output(decimal_point_output), .digit_out(digit_out)
   );

   task automatic finish_test();
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Waits until digit d is driven, then compares its decimal point and segments.
   task automatic look(input int d, input logic [7:0] exp);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (digit_out !== 8'(1 << d) && n < 3 * SLOT * 8) begin
         @(negedge ref_clk);
         n++;
      end
      check(16'(digit_out), 16'(1 << d));
      check(16'({decimal_point_output, segment_out}), 16'(exp));
   endtask : look

   task automatic test_seq_raw();
      host_u.write(1'b1, 8'hB0);
      for (int d = 0; d < 9; d++) begin
         host_u.write(1'b0, (d < 8) ? 8'(8'h11 * (d + 1)) : 8'hFF);
      end
      for (int d = 0; d < 8; d++) begin
         look(d, 8'(8'h11 * (d + 1)));
      end
   endtask : test_seq_raw

   task automatic test_single();
      host_u.write(1'b1, 8'h36);
      host_u.write(1'b0, 8'h5A);
      look(6, 8'h5A);
      look(3, 8'h44);
      look(5, 8'h66);
   endtask : test_single

   task automatic test_decode();
      host_u.write(1'b1, 8'h18);
      host_u.write(1'b0, 8'h8A);
      look(0, 8'hC0);
      host_u.write(1'b1, 8'h50);
      host_u.write(1'b0, 8'h0C);
      look(0, 8'h39);
      host_u.write(1'b1, 8'h58);
      look(0, 8'hF7);
   endtask : test_decode

   task automatic test_shutdown();
      int lit;
      lit = 0;
      host_u.write(1'b1, 8'h48);
      repeat (2) @(posedge ref_clk);
      repeat (3 * SLOT * 8) begin
         @(negedge ref_clk);
         if (digit_out !== 8'h00 || segment_out !== 7'h00) lit++;
      end
      check(16'(lit != 0), 16'h0000);
      host_u.write(1'b1, 8'h58);
      look(0, 8'hF7);
   endtask : test_shutdown

   task automatic test_scan();
      int on_c;
      int per_c;
      on_c = 0;
      look(1, 8'h5B);
      look(0, 8'hF7);
      while (digit_out[0] === 1'b1 && on_c < SLOT) begin
         @(negedge ref_clk);
         on_c++;
      end
      per_c = on_c;
      while (digit_out[0] !== 1'b1 && per_c < 2 * SLOT * 8) begin
         @(negedge ref_clk);
         per_c++;
      end
      check(16'(on_c), 16'(SLOT - LDW_BLANK_CYC));
      check(16'(per_c), 16'(SLOT * LDW_DIGITS));
   endtask : test_scan

   initial begin
      repeat (6) @(posedge ref_clk);
      check(16'({digit_out, decimal_point_output, segment_out}), 16'h0000);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      test_seq_raw();
      test_single();
      test_decode();
      test_shutdown();
      test_scan();
      finish_test();
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      err_count++;
      finish_test();
   end
endmodule : ldw_top_tb
`default_nettype wire
